// >>> rtl/synth_config_status_regs.sv
// What this block does
// - Low-power bits 4,0 set buffer modes, bit 2 the demux mode
// - Bit 26 enables modulator dithering
// - Bits 23:22 select modulator order
// - Bit 20 enables calibration auto restart
// - Manual oscillator and sub-band test fields
// - Bit 12 enables calibration temperature compensation
// - Bits 11:10 give one to four precharge slots
// - Bit 9 adds two accuracy calibration slots
// - Calibrator divider 1..511, zero means 511
// - Pin tri-state and open-drain/CMOS drive
// - Pin carries read data unless bit 23
// - Bits 22:21 choose pin source
// - Bit 19 enables cycle slip
// - Fast lock uses switch pin, pump current
// - Fast-lock slot lasts programmed detector cycles
// - Bit 26 lets out1 pin power both
// - Four regulator voltage fields default 2.6 V
// - High-voltage regulator voltage code bits 1:0
// - Status shows regulator start, over-current
// - Status shows lock, oscillator, sub-band
module synth_config_status_regs #(
  parameter int unsigned DW = synth_cfg_pkg::DATA_W
) (
  input  wire logic          mclk,
  input  wire logic          arst_n,
  input  wire logic          reg_wr_en,
  input  wire logic          reg_rd_en,
  input  wire logic [3:0]    reg_addr,
  input  wire logic [DW-1:0] reg_wdata,
  output logic      [DW-1:0] reg_rdata,
  output logic               reg_rd_valid,
  input  wire logic          spi_read_active,
  input  wire logic          spi_sdo,
  input  wire logic          lock_detect_in,
  input  wire logic          vco_div_in,
  input  wire logic          cal_div_in,
  input  wire logic          fl_clk_in,
  input  wire logic          pfd_tick_in,
  input  wire logic          fast_lock_start,
  input  wire logic [4:0]    ldo_started_in,
  input  wire logic [4:0]    ldo_overcurrent_in,
  input  wire logic [1:0]    cal_osc_in,
  input  wire logic [4:0]    cal_subband_in,
  input  wire logic          out1_powerdown_pin,
  input  wire logic          out2_powerdown_pin,
  output logic               lockout_pin_o,
  output logic               lockout_pin_oe,
  output logic               out2_buffer_low_power,
  output logic               rf_demux_low_power,
  output logic               ref_buffer_low_power,
  output logic               dither_enable,
  output logic [2:0]         modulator_order,
  output logic               calib_auto_restart,
  output logic [1:0]         osc_core_select,
  output logic [4:0]         osc_subband_manual,
  output logic               calib_temp_comp,
  output logic [2:0]         tune_precharge_slots,
  output logic [2:0]         calib_extra_slots,
  output logic [8:0]         calib_div_ratio,
  output logic               cycle_slip_enable,
  output logic               fast_lock_active,
  output logic [4:0]         pump_current_sel,
  output logic               out1_powered_down,
  output logic               out2_powered_down,
  output logic [1:0]         logic_ldo_voltage,
  output logic [1:0]         ref_ldo_voltage,
  output logic [1:0]         rf_ldo_voltage,
  output logic [1:0]         vco_ldo_voltage,
  output logic [1:0]         highv_ldo_voltage
);

  logic [DW-1:0] low_power_control_r;
  logic [DW-1:0] calibrator_modulator_config_r;
  logic [DW-1:0] fast_lock_pin_config_r;
  logic [DW-1:0] regulator_config_r;
  logic [DW-1:0] test_init_word_r;
  logic [DW-1:0] status_word, rdata_nxt;
  logic [12:0]   fl_cnt_r;
  logic          pin_val_nxt, pin_src, tick_d_r, tick_rise;
  // Two-stage synchronisers for everything from the analog side
  localparam int unsigned NSYNC = 24;
  logic [NSYNC-1:0] async_in, sync1_r, sync2_r;
  assign async_in = {pfd_tick_in, out2_powerdown_pin, out1_powerdown_pin,
                     fl_clk_in, cal_div_in, vco_div_in, lock_detect_in,
                     cal_subband_in, cal_osc_in, ldo_overcurrent_in,
                     ldo_started_in};

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end
  logic [4:0] ldo_start_s, ldo_ocp_s, sub_s;
  logic [1:0] osc_s;
  logic       lock_s, vco_div_s, cal_div_s, fl_clk_s, pd1_s, pd2_s, tick_s;
  assign {tick_s, pd2_s, pd1_s, fl_clk_s, cal_div_s, vco_div_s, lock_s,
          sub_s, osc_s, ldo_ocp_s, ldo_start_s} = sync2_r;

  // Register writes; status word has no storage behind it
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      low_power_control_r           <= synth_cfg_pkg::RST_WORD;
      calibrator_modulator_config_r <= synth_cfg_pkg::RST_WORD;
      fast_lock_pin_config_r        <= synth_cfg_pkg::RST_WORD;
      regulator_config_r            <= synth_cfg_pkg::RST_WORD;
      test_init_word_r              <= synth_cfg_pkg::RST_WORD;
    end
    else if (reg_wr_en)
    begin
      case (reg_addr)
        synth_cfg_pkg::OFS_LOW_POWER: low_power_control_r <= reg_wdata;
        synth_cfg_pkg::OFS_CAL_MOD:
          calibrator_modulator_config_r <= reg_wdata;
        synth_cfg_pkg::OFS_FAST_LOCK: fast_lock_pin_config_r <= reg_wdata;
        synth_cfg_pkg::OFS_REGULATOR: regulator_config_r <= reg_wdata;
        // Kept only for readback; host clears it first after power-up
        synth_cfg_pkg::OFS_TEST_INIT: test_init_word_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  assign status_word = {9'h000, ldo_start_s, ldo_ocp_s, lock_s,
                        osc_s, sub_s};

  always_comb
  begin
    case (reg_addr)
      synth_cfg_pkg::OFS_LOW_POWER: rdata_nxt = low_power_control_r;
      synth_cfg_pkg::OFS_CAL_MOD:   rdata_nxt = calibrator_modulator_config_r;
      synth_cfg_pkg::OFS_FAST_LOCK: rdata_nxt = fast_lock_pin_config_r;
      synth_cfg_pkg::OFS_REGULATOR: rdata_nxt = regulator_config_r;
      synth_cfg_pkg::OFS_TEST_INIT: rdata_nxt = test_init_word_r;
      synth_cfg_pkg::OFS_STATUS:    rdata_nxt = status_word;
      default:                      rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata    <= '0;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en)
        reg_rdata <= rdata_nxt;
    end
  end

  // Field decode
  assign out2_buffer_low_power =
    low_power_control_r[synth_cfg_pkg::LP_OUT2_BIT];
  assign rf_demux_low_power =
    low_power_control_r[synth_cfg_pkg::LP_DEMUX_BIT];
  assign ref_buffer_low_power =
    low_power_control_r[synth_cfg_pkg::LP_REF_BIT];
  logic [1:0] order_code;
  logic [8:0] div_field;
  assign dither_enable =
    calibrator_modulator_config_r[synth_cfg_pkg::CM_DITHER_BIT];
  assign order_code = calibrator_modulator_config_r[
    synth_cfg_pkg::CM_ORDER_LSB +: 2];
  always_comb
  begin
    case (order_code)
      synth_cfg_pkg::ORD_THIRD:  modulator_order = 3'h3;
      synth_cfg_pkg::ORD_SECOND: modulator_order = 3'h2;
      synth_cfg_pkg::ORD_FIRST:  modulator_order = 3'h1;
      synth_cfg_pkg::ORD_FOURTH: modulator_order = 3'h4;
      default:                   modulator_order = 3'h3;
    endcase
  end
  // Variants without auto restart rely on the host keeping this zero
  assign calib_auto_restart =
    calibrator_modulator_config_r[synth_cfg_pkg::CM_AUTOCAL_BIT];
  assign osc_core_select = calibrator_modulator_config_r[
    synth_cfg_pkg::CM_OSC_LSB +: 2];
  assign osc_subband_manual = calibrator_modulator_config_r[
    synth_cfg_pkg::CM_SUBBAND_LSB +: 5];
  assign calib_temp_comp =
    calibrator_modulator_config_r[synth_cfg_pkg::CM_TEMPCOMP_BIT];
  assign tune_precharge_slots = {1'b0, calibrator_modulator_config_r[
    synth_cfg_pkg::CM_PRCHG_LSB +: 2]} + 3'h1;
  assign calib_extra_slots =
    calibrator_modulator_config_r[synth_cfg_pkg::CM_ACC_BIT] ?
    synth_cfg_pkg::CAL_ACC_EXTRA : 3'h0;
  assign div_field = calibrator_modulator_config_r[
    synth_cfg_pkg::CM_DIV_LSB +: 9];
  assign calib_div_ratio = (div_field == 9'h000) ?
    synth_cfg_pkg::CAL_DIV_MAX : div_field;
  assign cycle_slip_enable =
    fast_lock_pin_config_r[synth_cfg_pkg::FL_SLIP_BIT];
  assign pump_current_sel = fast_lock_pin_config_r[
    synth_cfg_pkg::FL_PUMP_LSB +: 5];
  // Fast-lock slot timer, counted in detector cycles
  assign tick_rise = tick_s & ~tick_d_r;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tick_d_r <= 1'b0;
      fl_cnt_r <= '0;
    end
    else
    begin
      tick_d_r <= tick_s;
      if (fast_lock_start &&
          fast_lock_pin_config_r[synth_cfg_pkg::FL_EN_BIT])
        fl_cnt_r <= fast_lock_pin_config_r[
          synth_cfg_pkg::FL_DUR_LSB +: 13];
      else if (tick_rise && fl_cnt_r != 13'h0000)
        fl_cnt_r <= fl_cnt_r - 13'h0001;
    end
  end

  assign fast_lock_active = (fl_cnt_r != 13'h0000);
  // While fast lock owns the shared pin it no longer powers down out2
  assign out1_powered_down = pd1_s;
  assign out2_powered_down =
    regulator_config_r[synth_cfg_pkg::RG_BYPASS_BIT] ? pd1_s :
    (fast_lock_pin_config_r[synth_cfg_pkg::FL_EN_BIT] ? 1'b0 : pd2_s);
  assign logic_ldo_voltage =
    regulator_config_r[synth_cfg_pkg::RG_DIG_LSB +: 2];
  assign ref_ldo_voltage =
    regulator_config_r[synth_cfg_pkg::RG_REF_LSB +: 2];
  assign rf_ldo_voltage =
    regulator_config_r[synth_cfg_pkg::RG_RF_LSB +: 2];
  assign vco_ldo_voltage =
    regulator_config_r[synth_cfg_pkg::RG_VCO_LSB +: 2];
  assign highv_ldo_voltage =
    regulator_config_r[synth_cfg_pkg::RG_HV_LSB +: 2];
  // Lock / read-data pin
  logic       lockout_pin_hiz, lockout_pin_drive_type, sdo_disable;
  logic [1:0] lockout_pin_source;
  assign lockout_pin_hiz = fast_lock_pin_config_r[synth_cfg_pkg::FL_HIZ_BIT];
  assign lockout_pin_drive_type =
    fast_lock_pin_config_r[synth_cfg_pkg::FL_CMOS_BIT];
  assign sdo_disable = fast_lock_pin_config_r[synth_cfg_pkg::FL_NOSDO_BIT];
  assign lockout_pin_source =
    fast_lock_pin_config_r[synth_cfg_pkg::FL_SRC_LSB +: 2];

  always_comb
  begin
    case (lockout_pin_source)
      synth_cfg_pkg::SRC_LOCK:    pin_src = lock_s;
      synth_cfg_pkg::SRC_VCO_DIV: pin_src = vco_div_s;
      synth_cfg_pkg::SRC_CAL_DIV: pin_src = cal_div_s;
      synth_cfg_pkg::SRC_FL_CLK:  pin_src = fl_clk_s;
      default:                    pin_src = lock_s;
    endcase
  end
  assign pin_val_nxt = (spi_read_active && !sdo_disable) ?
    spi_sdo : pin_src;
  // Open drain only ever pulls low; a high level comes from the pull-up
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lockout_pin_o  <= 1'b0;
      lockout_pin_oe <= 1'b0;
    end
    else
    begin
      lockout_pin_o  <= lockout_pin_drive_type & pin_val_nxt;
      lockout_pin_oe <= !lockout_pin_hiz &&
        (lockout_pin_drive_type || !pin_val_nxt);
    end
  end
  default clocking assert_clk @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence wr_to(logic [3:0] a);
    reg_wr_en && reg_addr == a;
  endsequence
  sequence rd_of(logic [3:0] a);
    reg_rd_en && reg_addr == a;
  endsequence
  sequence fl_load;
    fast_lock_start && fast_lock_pin_config_r[synth_cfg_pkg::FL_EN_BIT] &&
    fast_lock_pin_config_r[12:0] >= 13'h0002;
  endsequence
  low_power_wr_a: assert property (
    wr_to(synth_cfg_pkg::OFS_LOW_POWER) |=>
    out2_buffer_low_power == $past(reg_wdata[4]) &&
    ref_buffer_low_power == $past(reg_wdata[0]))
    else $error("low-power bits not taken from write");
  order_fourth_a: assert property (
    wr_to(synth_cfg_pkg::OFS_CAL_MOD) ##0 reg_wdata[23:22] == 2'h3 |=>
    modulator_order == 3'h4)
    else $error("code 11 did not give fourth order");
  div_zero_a: assert property (
    wr_to(synth_cfg_pkg::OFS_CAL_MOD) ##0 reg_wdata[8:0] == 9'h000 |=>
    calib_div_ratio == 9'h1ff)
    else $error("divider zero did not mean 511");
  status_ignore_a: assert property (
    wr_to(synth_cfg_pkg::OFS_STATUS) |=> $stable(low_power_control_r) &&
    $stable(calibrator_modulator_config_r) &&
    $stable(fast_lock_pin_config_r) && $stable(regulator_config_r))
    else $error("status write changed a register");
  status_zero_a: assert property (
    rd_of(synth_cfg_pkg::OFS_STATUS) |=> reg_rd_valid &&
    reg_rdata[26:18] == 9'h000 && reg_rdata[7] == $past(lock_s))
    else $error("status readback wrong");
  sdo_switch_a: assert property (
    spi_read_active && !sdo_disable && lockout_pin_drive_type &&
    !lockout_pin_hiz |=> lockout_pin_oe && lockout_pin_o == $past(spi_sdo))
    else $error("pin not carrying read data");
  pin_hiz_a: assert property (
    lockout_pin_hiz ##1 lockout_pin_hiz |-> !lockout_pin_oe)
    else $error("pin driven while tri-stated");
  // A second start right after the load may legally reload a short count
  fast_lock_run_a: assert property (
    fl_load ##1 !fast_lock_start |-> fast_lock_active [*2])
    else $error("fast-lock slot ended too early");
  out2_bypass_a: assert property (
    regulator_config_r[synth_cfg_pkg::RG_BYPASS_BIT] |->
    out2_powered_down == out1_powered_down)
    else $error("out2 not following out1 pin");
endmodule

// >>> rtl/synth_cfg_pkg.sv
package synth_cfg_pkg;
  localparam int unsigned DATA_W = 27;
  localparam int unsigned ADDR_W = 4;
  // Register offsets on the serial port address field
  localparam logic [3:0] OFS_LOW_POWER  = 4'h5;
  localparam logic [3:0] OFS_CAL_MOD    = 4'h6;
  localparam logic [3:0] OFS_FAST_LOCK  = 4'h7;
  localparam logic [3:0] OFS_REGULATOR  = 4'h8;
  localparam logic [3:0] OFS_TEST_INIT  = 4'h9;
  localparam logic [3:0] OFS_STATUS     = 4'ha;
  // Values after reset
  localparam logic [26:0] RST_WORD = 27'h0000000;
  // Low-power word
  localparam int unsigned LP_OUT2_BIT  = 4;
  localparam int unsigned LP_DEMUX_BIT = 2;
  localparam int unsigned LP_REF_BIT   = 0;
  // Calibrator / modulator word
  localparam int unsigned CM_DITHER_BIT   = 26;
  localparam int unsigned CM_ORDER_LSB    = 22;
  localparam int unsigned CM_AUTOCAL_BIT  = 20;
  localparam int unsigned CM_OSC_LSB      = 18;
  localparam int unsigned CM_SUBBAND_LSB  = 13;
  localparam int unsigned CM_TEMPCOMP_BIT = 12;
  localparam int unsigned CM_PRCHG_LSB    = 10;
  localparam int unsigned CM_ACC_BIT      = 9;
  localparam int unsigned CM_DIV_LSB      = 0;
  localparam logic [8:0]  CAL_DIV_MAX     = 9'h1ff;
  localparam logic [2:0]  CAL_ACC_EXTRA   = 3'h2;
  // Modulator order codes
  localparam logic [1:0] ORD_THIRD  = 2'h0;
  localparam logic [1:0] ORD_SECOND = 2'h1;
  localparam logic [1:0] ORD_FIRST  = 2'h2;
  localparam logic [1:0] ORD_FOURTH = 2'h3;
  // Fast-lock / pin word
  localparam int unsigned FL_HIZ_BIT     = 25;
  localparam int unsigned FL_CMOS_BIT    = 24;
  localparam int unsigned FL_NOSDO_BIT   = 23;
  localparam int unsigned FL_SRC_LSB     = 21;
  localparam int unsigned FL_SLIP_BIT    = 19;
  localparam int unsigned FL_EN_BIT      = 18;
  localparam int unsigned FL_PUMP_LSB    = 13;
  localparam int unsigned FL_DUR_LSB     = 0;
  // Pin source codes
  localparam logic [1:0] SRC_LOCK    = 2'h0;
  localparam logic [1:0] SRC_VCO_DIV = 2'h1;
  localparam logic [1:0] SRC_CAL_DIV = 2'h2;
  localparam logic [1:0] SRC_FL_CLK  = 2'h3;
  // Regulator word
  localparam int unsigned RG_BYPASS_BIT = 26;
  localparam int unsigned RG_DIG_LSB    = 16;
  localparam int unsigned RG_REF_LSB    = 12;
  localparam int unsigned RG_RF_LSB     = 8;
  localparam int unsigned RG_VCO_LSB    = 4;
  localparam int unsigned RG_HV_LSB     = 0;
  // Status word
  localparam int unsigned ST_START_LSB = 13;
  localparam int unsigned ST_OCP_LSB   = 8;
  localparam int unsigned ST_LOCK_BIT  = 7;
  localparam int unsigned ST_OSC_LSB   = 5;
  localparam int unsigned ST_SUB_LSB   = 0;
  localparam int unsigned N_LDO        = 5;
endpackage

// >>> tb/host_port_model.sv
module host_port_model (
  input  wire logic        mclk,
  output logic             reg_wr_en,
  output logic             reg_rd_en,
  output logic [3:0]       reg_addr,
  output logic [26:0]      reg_wdata,
  input  wire logic [26:0] reg_rdata,
  input  wire logic        reg_rd_valid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 27'h0;
  end

  // Released lines show the inverse so stale values are never trusted
  task automatic wr(input logic [3:0] a, input logic [26:0] d);
    @(negedge mclk);
    reg_wr_en = 1'b1;
    reg_addr  = a;
    reg_wdata = (a == 4'h5) ? (d & 27'h15) : d;
    @(negedge mclk);
    reg_wr_en = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~reg_wdata;
  endtask

  task automatic rd(input logic [3:0] a, output logic [26:0] d,
                    output logic ok);
    int i;
    @(negedge mclk);
    reg_rd_en = 1'b1;
    reg_addr  = a;
    @(negedge mclk);
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
    for (i = 0; i < 3 && reg_rd_valid !== 1'b1; i++)
      @(negedge mclk);
    ok = (reg_rd_valid === 1'b1);
    d  = reg_rdata;
  endtask

  // Test word cleared before anything else is programmed
  task automatic init_seq();
    wr(4'h9, 27'h0);
  endtask
endmodule

// >>> tb/synth_config_status_regs_tb_top.sv
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
    end \
  end

module synth_config_status_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk, arst_n, reg_wr_en, reg_rd_en, reg_rd_valid;
  logic [3:0]  reg_addr;
  logic [26:0] reg_wdata, reg_rdata, rdv, w;
  logic        spi_read_active, spi_sdo, lock_detect_in, vco_div_in;
  logic        cal_div_in, fl_clk_in, pfd_tick_in, fast_lock_start;
  logic [4:0]  ldo_started_in, ldo_overcurrent_in, cal_subband_in;
  logic [1:0]  cal_osc_in, osc_core_select, logic_ldo_voltage;
  logic [1:0]  ref_ldo_voltage, rf_ldo_voltage, vco_ldo_voltage;
  logic [1:0]  highv_ldo_voltage;
  logic        out1_powerdown_pin, out2_powerdown_pin, lockout_pin_o;
  logic        lockout_pin_oe, out2_buffer_low_power, rf_demux_low_power;
  logic        ref_buffer_low_power, dither_enable, calib_auto_restart;
  logic        calib_temp_comp, cycle_slip_enable, fast_lock_active;
  logic        out1_powered_down, out2_powered_down, ok;
  logic [2:0]  modulator_order, tune_precharge_slots, calib_extra_slots;
  logic [4:0]  osc_subband_manual, pump_current_sel;
  logic [8:0]  calib_div_ratio;
  logic [1:0]  kk;
  logic [2:0]  ord_exp [4] = '{3'h3, 3'h2, 3'h1, 3'h4};
  int          err_count = 0;
  int          n_tests = 0;
  int          cyc = 0;

  synth_config_status_regs u_synth_config_status_regs (
    .mclk, .arst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rd_valid, .spi_read_active, .spi_sdo,
    .lock_detect_in, .vco_div_in, .cal_div_in, .fl_clk_in, .pfd_tick_in,
    .fast_lock_start, .ldo_started_in, .ldo_overcurrent_in, .cal_osc_in,
    .cal_subband_in, .out1_powerdown_pin, .out2_powerdown_pin,
    .lockout_pin_o, .lockout_pin_oe, .out2_buffer_low_power,
    .rf_demux_low_power, .ref_buffer_low_power, .dither_enable,
    .modulator_order, .calib_auto_restart, .osc_core_select,
    .osc_subband_manual, .calib_temp_comp, .tune_precharge_slots,
    .calib_extra_slots, .calib_div_ratio, .cycle_slip_enable,
    .fast_lock_active, .pump_current_sel, .out1_powered_down,
    .out2_powered_down, .logic_ldo_voltage, .ref_ldo_voltage,
    .rf_ldo_voltage, .vco_ldo_voltage, .highv_ldo_voltage
  );

  host_port_model u_host_port_model (
    .mclk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rd_valid
  );

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic test_done();
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Ceiling well above the roughly two hundred cycles the sequence needs
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      $display("unexpected at %0t: timeout", $time);
      test_done();
    end
  end

  // Async inputs pass two sync stages plus the output register
  task automatic settle();
    repeat (5) @(negedge mclk);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [26:0] e);
    u_host_port_model.rd(a, rdv, ok);
    `CHK(ok, 1'b1)
    `CHK(rdv, e)
  endtask

  task automatic wrrd(input logic [3:0] a, input logic [26:0] d);
    u_host_port_model.wr(a, d);
    rdchk(a, d);
  endtask

  task automatic tick();
    pfd_tick_in = 1'b1;
    repeat (2) @(negedge mclk);
    pfd_tick_in = 1'b0;
    repeat (2) @(negedge mclk);
  endtask

  initial
  begin
    arst_n = 1'b0;
    {spi_read_active, spi_sdo, pfd_tick_in, fast_lock_start} = 4'h0;
    {out1_powerdown_pin, out2_powerdown_pin} = 2'h0;
    {fl_clk_in, cal_div_in, vco_div_in, lock_detect_in} = 4'h0;
    {ldo_started_in, ldo_overcurrent_in, cal_osc_in, cal_subband_in} = '0;
    // Clock start at time zero looks like a falling edge
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    arst_n = 1'b1;
    `CHK(tune_precharge_slots, 3'h1)
    `CHK(calib_div_ratio, 9'h1ff)
    `CHK(modulator_order, 3'h3)
    `CHK({logic_ldo_voltage, ref_ldo_voltage}, 4'h0)
    `CHK(rf_ldo_voltage, 2'h0)
    `CHK(vco_ldo_voltage, 2'h0)
    u_host_port_model.init_seq();
    rdchk(4'h9, 27'h0);
    wrrd(4'h5, 27'h15);
    `CHK({out2_buffer_low_power, rf_demux_low_power}, 2'h3)
    `CHK(ref_buffer_low_power, 1'b1)
    wrrd(4'h5, 27'h04);
    `CHK({out2_buffer_low_power, rf_demux_low_power}, 2'h1)
    `CHK(ref_buffer_low_power, 1'b0)
    for (int k = 0; k < 4; k++)
    begin
      kk = 2'(k);
      w = {1'b1, 2'b00, kk, 1'b0, 1'b1, kk, 5'(k * 9), 1'b1, kk, 1'b1, 9'(k)};
      wrrd(4'h6, w);
      `CHK(dither_enable, 1'b1)
      `CHK(modulator_order, ord_exp[k])
      `CHK({calib_auto_restart, osc_core_select}, {1'b1, kk})
      `CHK(osc_subband_manual, 5'(k * 9))
      `CHK(calib_temp_comp, 1'b1)
      `CHK(tune_precharge_slots, 3'(k + 1))
      `CHK(calib_extra_slots, 3'h2)
      `CHK(calib_div_ratio, (k == 0) ? 9'h1ff : 9'(k))
    end
    wrrd(4'h6, 27'h0);
    `CHK({dither_enable, calib_temp_comp, calib_extra_slots}, 5'h0)
    `CHK(calib_auto_restart, 1'b0)
    out2_powerdown_pin = 1'b1;
    settle();
    `CHK(out2_powered_down, 1'b1)
    wrrd(4'h8, 27'h4012313);
    settle();
    `CHK(out2_powered_down, 1'b0)
    out1_powerdown_pin = 1'b1;
    settle();
    `CHK({out1_powered_down, out2_powered_down}, 2'h3)
    `CHK({logic_ldo_voltage, ref_ldo_voltage}, 4'h6)
    `CHK(rf_ldo_voltage, 2'h3)
    `CHK({vco_ldo_voltage, highv_ldo_voltage}, 4'h7)
    out1_powerdown_pin = 1'b0;
    u_host_port_model.wr(4'h8, 27'h3);
    for (int k = 0; k < 4; k++)
    begin
      u_host_port_model.wr(4'h7, 27'h1800000 | (27'(k) << 21));
      {fl_clk_in, cal_div_in, vco_div_in, lock_detect_in} = 4'(1 << k);
      settle();
      `CHK({lockout_pin_oe, lockout_pin_o}, 2'h3)
      {fl_clk_in, cal_div_in, vco_div_in, lock_detect_in} = ~4'(1 << k);
      settle();
      `CHK({lockout_pin_oe, lockout_pin_o}, 2'h2)
    end
    {fl_clk_in, cal_div_in, vco_div_in, lock_detect_in} = 4'h1;
    spi_read_active = 1'b1;
    u_host_port_model.wr(4'h7, 27'h1000000);
    settle();
    `CHK({lockout_pin_oe, lockout_pin_o}, 2'h2)
    spi_sdo = 1'b1;
    settle();
    `CHK({lockout_pin_oe, lockout_pin_o}, 2'h3)
    spi_sdo = 1'b0;
    u_host_port_model.wr(4'h7, 27'h1800000);
    settle();
    `CHK({lockout_pin_oe, lockout_pin_o}, 2'h3)
    spi_read_active = 1'b0;
    u_host_port_model.wr(4'h7, 27'h0);
    settle();
    `CHK({lockout_pin_oe, lockout_pin_o}, 2'h0)
    lock_detect_in = 1'b0;
    settle();
    `CHK({lockout_pin_oe, lockout_pin_o}, 2'h2)
    u_host_port_model.wr(4'h7, 27'h2000000);
    settle();
    `CHK(lockout_pin_oe, 1'b0)
    @(negedge mclk);
    fast_lock_start = 1'b1;
    @(negedge mclk);
    fast_lock_start = 1'b0;
    `CHK(fast_lock_active, 1'b0)
    wrrd(4'h7, 27'h00ea003);
    settle();
    `CHK({cycle_slip_enable, pump_current_sel}, 6'h35)
    `CHK(out2_powered_down, 1'b0)
    @(negedge mclk);
    fast_lock_start = 1'b1;
    @(negedge mclk);
    fast_lock_start = 1'b0;
    `CHK(fast_lock_active, 1'b1)
    tick();
    tick();
    `CHK(fast_lock_active, 1'b1)
    tick();
    repeat (2) @(negedge mclk);
    `CHK(fast_lock_active, 1'b0)
    {ldo_started_in, ldo_overcurrent_in} = {5'h15, 5'h0a};
    {lock_detect_in, cal_osc_in, cal_subband_in} = {1'b1, 2'h2, 5'h13};
    settle();
    w = {9'h0, 5'h15, 5'h0a, 1'b1, 2'h2, 5'h13};
    rdchk(4'ha, w);
    u_host_port_model.wr(4'ha, 27'h7ffffff);
    rdchk(4'ha, w);
    rdchk(4'hf, 27'h0);
    test_done();
  end
endmodule
